// [common/ofrc_pkg.sv]
package ofrc_pkg;
  // command codes of the limit registers
  localparam logic [7:0]  OFRC_CMD_OV_WARN   = 8'h42;
  localparam logic [7:0]  OFRC_CMD_UV_WARN   = 8'h43;
  localparam logic [7:0]  OFRC_CMD_UV_FAULT  = 8'h44;
  // fault-response byte layout
  localparam int          OFRC_RESP_HI       = 7;
  localparam int          OFRC_RESP_LO       = 6;
  localparam int          OFRC_RETRY_HI      = 5;
  localparam int          OFRC_RETRY_LO      = 3;
  localparam int          OFRC_DELAY_HI      = 2;
  localparam int          OFRC_DELAY_LO      = 0;
  // reset values and retry codes
  localparam logic [15:0] OFRC_LIMIT_RST     = 16'h0000;
  localparam logic [7:0]  OFRC_RESP_RST      = 8'h00;
  localparam logic [2:0]  OFRC_RETRY_NONE    = 3'h0;
  localparam logic [2:0]  OFRC_RETRY_FOREVER = 3'h7;
  // time unit: 1 us at 40 MHz gives 40 cycles per tick of the unit counter
  localparam int          OFRC_CLK_MHZ       = 40;
  localparam int          OFRC_TICK_NS       = 1000;
  localparam int          OFRC_TICK_CYC      = (OFRC_TICK_NS * OFRC_CLK_MHZ) / 1000;
  localparam logic [1:0]  OFRC_RESP_IGNORE   = 2'h0;
  localparam logic [1:0]  OFRC_RESP_CONTINUE = 2'h1;
  localparam logic [1:0]  OFRC_RESP_RETRY    = 2'h2;
  localparam logic [1:0]  OFRC_RESP_HOLD     = 2'h3;

  typedef enum logic [5:0] {
    OFRC_ON      = 6'h01,
    OFRC_GRACE   = 6'h02,
    OFRC_WAIT    = 6'h04,
    OFRC_RESTART = 6'h08,
    OFRC_HOLD    = 6'h10,
    OFRC_LATCHED = 6'h20
  } ofrc_state_t;

  // codes 0..7 -> 1,2,4,...,128 time units
  function automatic logic [7:0] ofrc_units(input logic [2:0] code);
    ofrc_units = 8'h01 << code;
  endfunction
endpackage

// [rtl/ofrc_sync.sv]
`timescale 1ns/1ps
module ofrc_sync import ofrc_pkg::*; #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_r <= '0;
      s2_r <= '0;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
    end
  end
  assign q = s2_r;
endmodule // ofrc_sync

// [rtl/ofrc_timer.sv]
`timescale 1ns/1ps
module ofrc_timer import ofrc_pkg::*; (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire logic [2:0]  code,
  input  wire logic [15:0] unit_ticks,
  output logic             done
);
  // ---------------------------------------------------------------
  // delay = units(code) * unit_ticks microsecond ticks
  // ---------------------------------------------------------------
  logic [5:0]  pre_r;
  logic [5:0]  pre_nxt;
  logic [23:0] cnt_r;
  logic [23:0] cnt_nxt;
  logic        run_r;
  logic        run_nxt;
  logic        done_r;
  logic        done_nxt;
  logic        tick;

  always_comb begin
    tick     = run_r && (pre_r == 6'(OFRC_TICK_CYC - 1));
    pre_nxt  = (start || tick) ? 6'h00 : (run_r ? pre_r + 6'h01 : pre_r);
    cnt_nxt  = cnt_r;
    run_nxt  = run_r;
    done_nxt = 1'b0;
    if (start) begin
      // a zero unit length counts as one tick per unit so the delay is never zero
      cnt_nxt = 24'(ofrc_units(code)) * 24'((unit_ticks == 16'h0000) ? 16'h0001 : unit_ticks);
      run_nxt = 1'b1;
    end else if (tick) begin
      if (cnt_r <= 24'h000001) begin
        run_nxt  = 1'b0;
        done_nxt = 1'b1;
      end
      cnt_nxt = cnt_r - 24'h000001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pre_r  <= 6'h00;
      cnt_r  <= 24'h000000;
      run_r  <= 1'b0;
      done_r <= 1'b0;
    end else begin
      pre_r  <= pre_nxt;
      cnt_r  <= cnt_nxt;
      run_r  <= run_nxt;
      done_r <= done_nxt;
    end
  end
  assign done = done_r;
endmodule // ofrc_timer

// [rtl/ofrc_top.sv]
`timescale 1ns/1ps
// Summary of operation
// - retry code 011 gives three restarts
// - codes 100..110 give four to six
// - all restarts fail: output off, latched
// - code 111 retries until off or shutdown
// - restart spacing is units times time unit
// - delay code selects 1..128 time units
// - same delay for grace and spacing
// - time unit comes from separate register
// - 16-bit overvoltage warning threshold, read/write
// - 16-bit undervoltage warning threshold, read/write
// - 16-bit undervoltage fault threshold, read/write
// - response field: ignore, continue, retry, hold
// - clear by bit, command, on/off, power; warning flags clear by command or power only
// - retry code 000 means no restart
module ofrc_top import ofrc_pkg::*; (
  input  wire logic        REF_CLK,
  input  wire logic        RST,
  input  wire logic        WR_STB,
  input  wire logic        RD_STB,
  input  wire logic [7:0]  CMD_CODE,
  input  wire logic [15:0] WR_DATA,
  input  wire logic [7:0]  FAULT_RESP,
  input  wire logic [15:0] UNIT_TICKS,
  input  wire logic [15:0] VOUT_MEAS,
  input  wire logic        ON_CMD,
  input  wire logic        CLEAR_ALL,
  input  wire logic        CLEAR_BIT,
  input  wire logic        OTHER_FAULT,
  input  wire logic        RESTART_OK,
  output logic [15:0]      RD_DATA,
  output logic             RD_VALID,
  output logic             OUT_ENABLE,
  output logic             UV_FAULT_FLAG,
  output logic             OV_WARN_FLAG,
  output logic             UV_WARN_FLAG,
  output logic             RETRY_ACTIVE
);
  // ---------------------------------------------------------------
  // pin inputs
  // ---------------------------------------------------------------
  logic [15:0] vout_s;
  logic        on_s;
  logic        other_s;
  logic        ok_s;

  ofrc_sync #(.W(16)) u_sync_v (
    .clk (REF_CLK),
    .rst (RST),
    .d   (VOUT_MEAS),
    .q   (vout_s)
  );
  ofrc_sync #(.W(3)) u_sync_p (
    .clk (REF_CLK),
    .rst (RST),
    .d   ({ON_CMD, OTHER_FAULT, RESTART_OK}),
    .q   ({on_s, other_s, ok_s})
  );

  // bits of the word may settle a cycle apart in the synchroniser, so a
  // word is taken only once two samples in a row agree
  logic [15:0] vout_prev_r;
  logic [15:0] vout_q_r;
  logic [15:0] vout_q_nxt;

  always_comb begin
    vout_q_nxt = (vout_s == vout_prev_r) ? vout_s : vout_q_r;
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      vout_prev_r <= 16'h0000;
      vout_q_r    <= 16'h0000;
    end else begin
      vout_prev_r <= vout_s;
      vout_q_r    <= vout_q_nxt;
    end
  end

  // ---------------------------------------------------------------
  // limit registers
  // ---------------------------------------------------------------
  logic [15:0] ov_warn_r;
  logic [15:0] ov_warn_nxt;
  logic [15:0] uv_warn_r;
  logic [15:0] uv_warn_nxt;
  logic [15:0] uv_fault_r;
  logic [15:0] uv_fault_nxt;
  logic [15:0] rd_data_r;
  logic [15:0] rd_data_nxt;
  logic        rd_valid_r;
  logic        rd_valid_nxt;

  always_comb begin
    ov_warn_nxt  = ov_warn_r;
    uv_warn_nxt  = uv_warn_r;
    uv_fault_nxt = uv_fault_r;
    rd_data_nxt  = rd_data_r;
    rd_valid_nxt = RD_STB;
    if (WR_STB) begin
      unique case (CMD_CODE)
        OFRC_CMD_OV_WARN:  ov_warn_nxt  = WR_DATA;
        OFRC_CMD_UV_WARN:  uv_warn_nxt  = WR_DATA;
        OFRC_CMD_UV_FAULT: uv_fault_nxt = WR_DATA;
        default:           ;
      endcase
    end
    if (RD_STB) begin
      unique case (CMD_CODE)
        OFRC_CMD_OV_WARN:  rd_data_nxt = ov_warn_r;
        OFRC_CMD_UV_WARN:  rd_data_nxt = uv_warn_r;
        OFRC_CMD_UV_FAULT: rd_data_nxt = uv_fault_r;
        default:           rd_data_nxt = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      ov_warn_r  <= OFRC_LIMIT_RST;
      uv_warn_r  <= OFRC_LIMIT_RST;
      uv_fault_r <= OFRC_LIMIT_RST;
      rd_data_r  <= 16'h0000;
      rd_valid_r <= 1'b0;
    end else begin
      ov_warn_r  <= ov_warn_nxt;
      uv_warn_r  <= uv_warn_nxt;
      uv_fault_r <= uv_fault_nxt;
      rd_data_r  <= rd_data_nxt;
      rd_valid_r <= rd_valid_nxt;
    end
  end

  // ---------------------------------------------------------------
  // comparators and warnings
  // ---------------------------------------------------------------
  logic uv_now;
  logic ov_warn_r2;
  logic uv_warn_r2;
  logic ov_w_nxt;
  logic uv_w_nxt;
  logic on_d_r;
  logic on_cycle;
  logic clear_any;

  always_comb begin
    uv_now    = vout_q_r < uv_fault_r;
    on_cycle  = on_s && !on_d_r;
    clear_any = CLEAR_ALL || CLEAR_BIT || on_cycle;
    // flags are sticky; a new crossing in the clear cycle wins
    ov_w_nxt  = (vout_q_r > ov_warn_r) || (ov_warn_r2 && !CLEAR_ALL);
    uv_w_nxt  = (vout_q_r < uv_warn_r) || (uv_warn_r2 && !CLEAR_ALL);
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      ov_warn_r2 <= 1'b0;
      uv_warn_r2 <= 1'b0;
      on_d_r     <= 1'b0;
    end else begin
      ov_warn_r2 <= ov_w_nxt;
      uv_warn_r2 <= uv_w_nxt;
      on_d_r     <= on_s;
    end
  end

  // ---------------------------------------------------------------
  // fault-response sequencer
  // ---------------------------------------------------------------
  logic [1:0]  resp;
  logic [2:0]  retry_code;
  logic [2:0]  delay_code;
  ofrc_state_t st_r;
  ofrc_state_t st_nxt;
  logic [2:0]  tries_r;
  logic [2:0]  tries_nxt;
  logic        en_r;
  logic        en_nxt;
  logic        flt_r;
  logic        flt_nxt;
  logic        tmr_start;
  logic        tmr_done;
  logic        retry_nxt;

  assign resp       = FAULT_RESP[OFRC_RESP_HI:OFRC_RESP_LO];
  assign retry_code = FAULT_RESP[OFRC_RETRY_HI:OFRC_RETRY_LO];
  assign delay_code = FAULT_RESP[OFRC_DELAY_HI:OFRC_DELAY_LO];

  // one timer serves both grace time and restart spacing
  ofrc_timer u_timer (
    .clk        (REF_CLK),
    .rst        (RST),
    .start      (tmr_start),
    .code       (delay_code),
    .unit_ticks (UNIT_TICKS),
    .done       (tmr_done)
  );

  always_comb begin
    st_nxt    = st_r;
    tries_nxt = tries_r;
    en_nxt    = en_r;
    flt_nxt   = flt_r || uv_now;
    tmr_start = 1'b0;
    if (!on_s || other_s) begin
      // commanded off or shut by another fault ends any retrying
      st_nxt    = OFRC_ON;
      en_nxt    = 1'b0;
      tries_nxt = 3'h0;
      if (clear_any) flt_nxt = uv_now;
    end else begin
      unique case (st_r)
        OFRC_ON: begin
          en_nxt = 1'b1;
          if (clear_any) flt_nxt = uv_now;
          if (uv_now) begin
            unique case (resp)
              OFRC_RESP_IGNORE: ;
              OFRC_RESP_CONTINUE: begin
                st_nxt    = OFRC_GRACE;
                tmr_start = 1'b1;
              end
              OFRC_RESP_RETRY: begin
                en_nxt    = 1'b0;
                st_nxt    = OFRC_WAIT;
                tmr_start = 1'b1;
              end
              OFRC_RESP_HOLD: begin
                en_nxt = 1'b0;
                st_nxt = OFRC_HOLD;
              end
            endcase
          end
        end
        OFRC_GRACE: if (tmr_done) begin
          en_nxt    = !uv_now;
          st_nxt    = uv_now ? OFRC_WAIT : OFRC_ON;
          tmr_start = uv_now;
        end
        OFRC_WAIT: if (tmr_done) begin
          if (retry_code == OFRC_RETRY_NONE) begin
            st_nxt = OFRC_LATCHED;
            en_nxt = 1'b0;
          end else if (retry_code != OFRC_RETRY_FOREVER && tries_r >= retry_code) begin
            st_nxt = OFRC_LATCHED;
            en_nxt = 1'b0;
          end else begin
            tries_nxt = (retry_code == OFRC_RETRY_FOREVER) ? tries_r : tries_r + 3'h1;
            en_nxt    = 1'b1;
            st_nxt    = OFRC_RESTART;
            tmr_start = 1'b1;
          end
        end
        OFRC_RESTART: begin
          if (ok_s && !uv_now) begin
            st_nxt    = OFRC_ON;
            tries_nxt = 3'h0;
          end else if (tmr_done) begin
            // spacing counted from end of this attempt, when the output goes off
            en_nxt = 1'b0;
            st_nxt = OFRC_WAIT;
            tmr_start = 1'b1;
          end
        end
        OFRC_HOLD: if (!uv_now) begin
          en_nxt = 1'b1;
          st_nxt = OFRC_ON;
        end
        OFRC_LATCHED: if (clear_any) begin
          st_nxt    = OFRC_ON;
          tries_nxt = 3'h0;
          flt_nxt   = uv_now;
        end
        default: begin
          st_nxt = OFRC_LATCHED;
          en_nxt = 1'b0;
        end
      endcase
    end
    retry_nxt = (st_nxt == OFRC_WAIT) || (st_nxt == OFRC_RESTART);
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      st_r    <= OFRC_ON;
      tries_r <= 3'h0;
      en_r    <= 1'b0;
      flt_r   <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      tries_r <= tries_nxt;
      en_r    <= en_nxt;
      flt_r   <= flt_nxt;
    end
  end

  logic retry_r;
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      retry_r <= 1'b0;
    end else begin
      retry_r <= retry_nxt;
    end
  end

  assign RD_DATA       = rd_data_r;
  assign RD_VALID      = rd_valid_r;
  assign OUT_ENABLE    = en_r;
  assign UV_FAULT_FLAG = flt_r;
  assign OV_WARN_FLAG  = ov_warn_r2;
  assign UV_WARN_FLAG  = uv_warn_r2;
  assign RETRY_ACTIVE  = retry_r;
endmodule // ofrc_top

// [tb/ofrc_host.sv]
`timescale 1ns/1ps
module ofrc_host (
  input  wire logic        clk,
  input  wire logic [15:0] rd_data,
  input  wire logic        rd_valid,
  output logic             wr_stb,
  output logic             rd_stb,
  output logic [7:0]       cmd,
  output logic [15:0]      wdata
);
  // ----
  // host bus cycles
  // ----
  initial begin
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    cmd = 8'h00;
    wdata = 16'h0000;
  end
  // released lines carry the inverse, so a late sample sees junk, not stale data
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    @(negedge clk);
    cmd = c;
    wdata = d;
    wr_stb = 1'b1;
    @(negedge clk);
    wr_stb = 1'b0;
    cmd = ~c;
    wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] c, output logic v, output logic [15:0] d);
    @(negedge clk);
    cmd = c;
    rd_stb = 1'b1;
    @(negedge clk);
    rd_stb = 1'b0;
    cmd = ~c;
    v = rd_valid;
    d = rd_data;
  endtask
endmodule // ofrc_host

// [tb/ofrc_monitor.sv]
`timescale 1ns/1ps
module ofrc_monitor import ofrc_pkg::*; (
  input wire logic        REF_CLK,
  input wire logic        RST,
  input wire logic        RD_STB,
  input wire logic        ON_CMD,
  input wire logic        OTHER_FAULT,
  input wire logic [7:0]  FAULT_RESP,
  input wire logic [15:0] UNIT_TICKS,
  input wire logic        RD_VALID,
  input wire logic        OUT_ENABLE,
  input wire logic        RETRY_ACTIVE
);
  // ----
  // checks
  // ----
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  logic [31:0] off_cnt_r;
  logic [31:0] off_cnt_nxt;
  logic [31:0] exp_off;
  // off time is judged at the edge the output comes back, one cycle of slack below and six above for the timer
  always_comb begin
    off_cnt_nxt = OUT_ENABLE ? 32'h0 : off_cnt_r + 32'h1;
  end
  always_ff @(posedge REF_CLK) begin
    off_cnt_r <= RST ? 32'h0 : off_cnt_nxt;
  end
  assign exp_off = (32'h1 << FAULT_RESP[2:0]) * UNIT_TICKS * OFRC_TICK_CYC;
  property p_rd_valid; RD_STB |=> RD_VALID; endproperty
  a_rd_valid: assert property (p_rd_valid) else $error("read not answered");
  property p_rd_pulse; !RD_STB |=> !RD_VALID; endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("stray read valid");
  property p_other_off; OTHER_FAULT [*5] |-> !OUT_ENABLE; endproperty
  a_other_off: assert property (p_other_off) else $error("output on in shutdown");
  property p_on_off; !ON_CMD [*5] |-> !OUT_ENABLE && !RETRY_ACTIVE; endproperty
  a_on_off: assert property (p_on_off) else $error("output on while off");
  property p_rise_on; $rose(OUT_ENABLE) |-> $past(ON_CMD, 3); endproperty
  a_rise_on: assert property (p_rise_on) else $error("enable without on");
  property p_spacing;
    $rose(OUT_ENABLE) && RETRY_ACTIVE |-> off_cnt_r >= exp_off - 1 && off_cnt_r <= exp_off + 6;
  endproperty
  a_spacing: assert property (p_spacing) else $error("restart spacing wrong");
  property p_retry_off;
    $rose(RETRY_ACTIVE) && FAULT_RESP[7:6] == OFRC_RESP_RETRY |-> !OUT_ENABLE;
  endproperty
  a_retry_off: assert property (p_retry_off) else $error("retry with output on");
  property p_latched; $fell(RETRY_ACTIVE) && !OUT_ENABLE |=> !OUT_ENABLE [*8]; endproperty
  a_latched: assert property (p_latched) else $error("output back after give up");
  c_retry: cover property ($rose(RETRY_ACTIVE));
  c_read: cover property (RD_VALID);
  c_back: cover property ($rose(OUT_ENABLE) && RETRY_ACTIVE);
endmodule // ofrc_monitor

// [tb/tb_top.sv]
`timescale 1ns/1ps
module tb_top import ofrc_pkg::*; ;
  logic        ref_clk, rst, wr_stb, rd_stb, on_cmd, clr_all, clr_bit, oth, rok;
  logic        rvalid, oe, uvf, ovw, uvw, ract, oe_q, v;
  logic [7:0]  cmd, resp;
  logic [15:0] wdata, ticks, vout, rdata, d;
  logic [15:0] lim [3] = '{16'hA000, 16'h8800, 16'h8000};
  int          bad_count, samples_checked, cyc, starts;
  ofrc_top u_ofrc_top (.REF_CLK(ref_clk), .RST(rst), .WR_STB(wr_stb), .RD_STB(rd_stb),
    .CMD_CODE(cmd), .WR_DATA(wdata), .FAULT_RESP(resp), .UNIT_TICKS(ticks),
    .VOUT_MEAS(vout), .ON_CMD(on_cmd), .CLEAR_ALL(clr_all), .CLEAR_BIT(clr_bit),
    .OTHER_FAULT(oth), .RESTART_OK(rok), .RD_DATA(rdata), .RD_VALID(rvalid),
    .OUT_ENABLE(oe), .UV_FAULT_FLAG(uvf), .OV_WARN_FLAG(ovw), .UV_WARN_FLAG(uvw),
    .RETRY_ACTIVE(ract));
  ofrc_host u_ofrc_host (.clk(ref_clk), .rd_data(rdata), .rd_valid(rvalid),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .cmd(cmd), .wdata(wdata));
  // ----
  // helpers
  // ----
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic wait_oe(input logic e, input int n);
    for (int i = 0; i < n && oe !== e; i++)
      @(negedge ref_clk);
  endtask
  task automatic clr(input logic b);
    @(negedge ref_clk);
    clr_all = !b;
    clr_bit = b;
    @(negedge ref_clk);
    clr_all = 1'b0;
    clr_bit = 1'b0;
  endtask
  // bad output with no restart success: counts attempts until the block gives up
  task automatic retry_run(input logic [2:0] n, input logic [2:0] dc, input int e);
    resp = {OFRC_RESP_RETRY, n, dc};
    starts = 0;
    vout = 16'h1000;
    repeat (8) @(negedge ref_clk);
    for (int i = 0; i < 2500 && ract !== 1'b0; i++)
      @(negedge ref_clk);
    repeat (20) @(negedge ref_clk);
    chk("attempts", 16'(starts), 16'(e));
    chk("out_enable", oe, 1'b0);
    chk("uv_fault", uvf, 1'b1);
    vout = 16'h9000;
    repeat (5) @(negedge ref_clk);
    clr(n[0]);
    wait_oe(1'b1, 20);
    chk("out_enable", oe, 1'b1);
    chk("uv_fault", uvf, 1'b0);
    $display("retry run %0d done", n);
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(negedge ref_clk) begin
    oe_q <= oe;
    if (oe && !oe_q && ract)
      starts++;
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      complete_run();
    end
  end
  // ----
  // tests
  // ----
  initial begin
    {rst, on_cmd, ticks} = {1'b1, 1'b1, 16'h0001};
    {clr_all, clr_bit, oth, rok, oe_q} = 5'h00;
    resp = 8'h00;
    vout = 16'h9000;
    repeat (8) @(negedge ref_clk);
    rst = 1'b0;
    for (int i = 0; i < 3; i++) begin
      u_ofrc_host.rd(OFRC_CMD_OV_WARN + 8'(i), v, d);
      chk("read_valid", v, 1'b1);
      chk("limit_reset", d, OFRC_LIMIT_RST);
      u_ofrc_host.wr(OFRC_CMD_OV_WARN + 8'(i), lim[i]);
    end
    u_ofrc_host.wr(8'h45, 16'h1234);
    for (int i = 0; i < 4; i++) begin
      u_ofrc_host.rd(OFRC_CMD_OV_WARN + 8'(i), v, d);
      chk("limit", d, (i < 3) ? lim[i] : 16'h0000);
    end
    clr(1'b0);
    vout = 16'hB000;
    repeat (10) @(negedge ref_clk);
    chk("ov_warn", ovw, 1'b1);
    vout = 16'h8400;
    repeat (10) @(negedge ref_clk);
    chk("uv_warn", uvw, 1'b1);
    chk("out_enable", oe, 1'b1);
    vout = 16'h9000;
    clr(1'b0);
    repeat (3) @(negedge ref_clk);
    chk("ov_warn", ovw, 1'b0);
    $display("registers and warnings done");
    resp = {OFRC_RESP_IGNORE, 6'h00};
    vout = 16'h1000;
    repeat (100) @(negedge ref_clk);
    chk("out_enable", oe, 1'b1);
    resp = {OFRC_RESP_HOLD, 6'h00};
    wait_oe(1'b0, 10);
    chk("out_enable", oe, 1'b0);
    vout = 16'h9000;
    wait_oe(1'b1, 10);
    chk("out_enable", oe, 1'b1);
    clr(1'b0);
    resp = {OFRC_RESP_CONTINUE, 6'h00};
    vout = 16'h1000;
    repeat (20) @(negedge ref_clk);
    chk("out_enable", oe, 1'b1);
    wait_oe(1'b0, 60);
    chk("out_enable", oe, 1'b0);
    repeat (60) @(negedge ref_clk);
    chk("retry_active", ract, 1'b0);
    chk("out_enable", oe, 1'b0);
    vout = 16'h9000;
    repeat (5) @(negedge ref_clk);
    clr(1'b1);
    wait_oe(1'b1, 20);
    chk("out_enable", oe, 1'b1);
    $display("response modes done");
    retry_run(3'h0, 3'h0, 0);
    retry_run(3'h3, 3'h0, 3);
    ticks = 16'h0002;
    retry_run(3'h4, 3'h0, 4);
    ticks = 16'h0001;
    retry_run(3'h5, 3'h0, 5);
    retry_run(3'h6, 3'h1, 6);
    retry_run(3'h1, 3'h3, 1);
    resp = {OFRC_RESP_RETRY, 6'h18};
    starts = 0;
    vout = 16'h1000;
    for (int i = 0; i < 300 && starts < 1; i++)
      @(negedge ref_clk);
    {vout, rok} = {16'h9000, 1'b1};
    repeat (60) @(negedge ref_clk);
    chk("retry_active", ract, 1'b0);
    chk("out_enable", oe, 1'b1);
    rok = 1'b0;
    clr(1'b0);
    retry_run(3'h3, 3'h0, 3);
    resp = {OFRC_RESP_RETRY, 6'h38};
    starts = 0;
    vout = 16'h1000;
    for (int i = 0; i < 1000 && starts < 8; i++)
      @(negedge ref_clk);
    chk("retry_active", ract, 1'b1);
    oth = 1'b1;
    repeat (12) @(negedge ref_clk);
    chk("retry_active", ract, 1'b0);
    {oth, vout, on_cmd} = {1'b0, 16'h9000, 1'b0};
    repeat (12) @(negedge ref_clk);
    on_cmd = 1'b1;
    wait_oe(1'b1, 20);
    chk("out_enable", oe, 1'b1);
    chk("uv_fault", uvf, 1'b0);
    $display("unlimited retry done");
    complete_run();
  end
endmodule // tb_top
bind ofrc_top ofrc_monitor u_ofrc_monitor (.REF_CLK(REF_CLK), .RST(RST), .RD_STB(RD_STB),
  .ON_CMD(ON_CMD), .OTHER_FAULT(OTHER_FAULT), .FAULT_RESP(FAULT_RESP),
  .UNIT_TICKS(UNIT_TICKS), .RD_VALID(RD_VALID), .OUT_ENABLE(OUT_ENABLE),
  .RETRY_ACTIVE(RETRY_ACTIVE));
